// ---- logic/cmp_regs_pkg.sv ----
// Purpose: Shared constants for the comparator control register bank
// Assumes: 16-bit registers on a plain strobe port, word indices as addresses
// Notes: Offsets are word addresses of the register port
package cmp_regs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CODE_W = 10;
	localparam int CHAN_MIN = 2;
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_THRESHOLD = 4'h1;
	localparam logic [3:0] OFF_SELECT = 4'h2;
	localparam int BIT_SPAN = 0;
	localparam int BIT_INVERT = 1;
	localparam int BIT_GAIN = 2;
	localparam int BIT_STATE = 3;
	localparam int BIT_HYST = 4;
	localparam int BIT_EXTREF = 5;
	localparam int BIT_DAC_PIN_DRIVE_ENABLE = 8;
	localparam logic [15:0] CONTROL_WMASK = 16'h0137;
	localparam logic [15:0] RESET_CONTROL = 16'h0000;
	localparam logic [9:0] RESET_CODE = 10'h000;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		SRC_BANDGAP,
		SRC_HALF_SUPPLY,
		SRC_EXTERNAL
	} ref_src_t;
endpackage

// ---- logic/cmp_bus_if.sv ----
// Purpose: Register write path between the bank and the channel store
// Assumes: One clock domain
// Notes: Carries strobe, channel index and data
`timescale 1ns/100ps
`default_nettype none
interface cmp_bus_if #(parameter int CH = 4);
	logic wrCtrl;
	logic wrCode;
	logic [$clog2(CH)-1:0] chan;
	logic [15:0] wdata;
	logic [CH-1:0][15:0] ctrl;
	logic [CH-1:0][9:0] code;
	modport master(output wrCtrl, wrCode, chan, wdata, input ctrl, code);
	modport store(input wrCtrl, wrCode, chan, wdata, output ctrl, code);
endinterface
`default_nettype wire

// ---- logic/cmp_chan_store.sv ----
// Purpose: Per-channel control and threshold storage
// Assumes: Clock enable freezes all state
// Notes: Reads come straight from registers
`timescale 1ns/100ps
`default_nettype none
module cmp_chan_store
	import cmp_regs_pkg::*;
#(
	parameter int CH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	// Store side
	cmp_bus_if.store bus
);
	////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < CH; i++) begin : g_ch
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				bus.ctrl[i] <= RESET_CONTROL;
			end else if (clkEn && bus.wrCtrl && bus.chan == i) begin
				bus.ctrl[i] <= bus.wdata & CONTROL_WMASK;
			end
		end
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				bus.code[i] <= RESET_CODE;
			end else if (clkEn && bus.wrCode && bus.chan == i) begin
				bus.code[i] <= bus.wdata[CODE_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/comparator_control_regs.sv ----
// Purpose: Control and status register bank for a group of comparators
// Assumes: Comparator levels arrive asynchronously from analog side
// Notes: Channel selected through a select register
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module comparator_control_regs
	import cmp_regs_pkg::*;
#(
	parameter int CH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [DATA_W-1:0] rdata,
	// Analog side
	input wire logic [CH-1:0] cmpRaw,
	output logic [CH-1:0] cmpOut,
	output logic [CH-1:0] hystFalling,
	output logic [CH-1:0] gainHigh,
	output logic [CH-1:0][1:0] refSrc,
	output logic [CH-1:0][CODE_W-1:0] thresholdCode,
	// Shared DAC pin
	output logic dacPinDriveEnable,
	output logic [1:0] dacPinChan
);
	if (CH < CHAN_MIN || CH > 4) begin : g_bad_ch
		$error("CH must be 2 to 4");
	end

	cmp_bus_if #(.CH(CH)) bus ();
	logic [1:0] selFf;
	logic [CH-1:0] syncA;
	logic [CH-1:0] syncB;
	logic [CH-1:0] stateNow;

	////////////////////////////////////////////////////////////////////////
	// Write decode
	assign bus.wrCtrl = wrStb && addr == OFF_CONTROL;
	assign bus.wrCode = wrStb && addr == OFF_THRESHOLD;
	assign bus.chan = selFf[$clog2(CH)-1:0];
	assign bus.wdata = wdata;

	cmp_chan_store #(.CH(CH)) u_store (
		.clock(clock),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.bus(bus)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			selFf <= 2'h0;
		end else if (clkEn && wrStb && addr == OFF_SELECT && wdata < 16'(CH)) begin
			selFf <= wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparator level synchronisers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
		end else if (clkEn) begin
			syncA <= cmpRaw;
			syncB <= syncA;
		end
	end

	always_comb begin
		for (int i = 0; i < CH; i++) begin
			stateNow[i] = syncB[i] ^ bus.ctrl[i][BIT_INVERT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference source decode
	function automatic logic [1:0] ref_of(input logic [15:0] c);
		if (c[BIT_EXTREF]) begin
			ref_of = 2'(SRC_EXTERNAL);
		end else if (c[BIT_SPAN]) begin
			ref_of = 2'(SRC_HALF_SUPPLY);
		end else begin
			ref_of = 2'(SRC_BANDGAP);
		end
	endfunction

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmpOut <= '0;
			hystFalling <= '0;
			gainHigh <= '0;
			refSrc <= '0;
			thresholdCode <= '0;
		end else if (clkEn) begin
			for (int i = 0; i < CH; i++) begin
				cmpOut[i] <= stateNow[i];
				hystFalling[i] <= bus.ctrl[i][BIT_HYST];
				gainHigh[i] <= bus.ctrl[i][BIT_GAIN];
				refSrc[i] <= ref_of(bus.ctrl[i]);
				thresholdCode[i] <= bus.code[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared DAC pin arbitration
	logic anyOe;
	logic [1:0] winner;
	always_comb begin
		anyOe = 1'b0;
		winner = 2'h0;
		for (int i = CH - 1; i >= 0; i--) begin
			if (bus.ctrl[i][BIT_DAC_PIN_DRIVE_ENABLE]) begin
				anyOe = 1'b1;
				winner = 2'(i);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dacPinDriveEnable <= 1'b0;
			dacPinChan <= 2'h0;
		end else if (clkEn) begin
			dacPinDriveEnable <= anyOe;
			dacPinChan <= winner;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (clkEn) begin
			if (rdStb) begin
				unique case (addr)
					OFF_CONTROL: begin
						rdata <= bus.ctrl[bus.chan] | (16'(stateNow[bus.chan]) << BIT_STATE);
					end
					OFF_THRESHOLD: begin
						rdata <= {6'h00, bus.code[bus.chan]};
					end
					OFF_SELECT: begin
						rdata <= {14'h0000, selFf};
					end
					default: begin
						rdata <= '0;
					end
				endcase
			end else begin
				rdata <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [CH-1:0] oeBits;
	always_comb begin
		for (int i = 0; i < CH; i++) begin
			oeBits[i] = bus.ctrl[i][BIT_DAC_PIN_DRIVE_ENABLE];
		end
	end

	property p_invert;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) |-> cmpOut[0] == ($past(syncB[0]) ^ $past(bus.ctrl[0][BIT_INVERT]));
	endproperty
	a_invert: assert property (p_invert) else $error("output inversion wrong");

	property p_state_read;
		@(posedge clock) disable iff (!rst_n)
		clkEn && rdStb && addr == OFF_CONTROL ##1 clkEn |-> rdata[BIT_STATE] == $past(stateNow[bus.chan]);
	endproperty
	a_state_read: assert property (p_state_read) else $error("state bit wrong");

	property p_hyst;
		@(posedge clock) disable iff (!rst_n)
		clkEn && bus.wrCtrl && bus.chan == 0 ##1 clkEn ##1 clkEn |-> hystFalling[0] == $past(wdata[BIT_HYST], 2);
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis edge wrong");

	property p_gain;
		@(posedge clock) disable iff (!rst_n)
		clkEn && bus.wrCtrl && bus.chan == 0 ##1 clkEn ##1 clkEn |-> gainHigh[0] == $past(wdata[BIT_GAIN], 2);
	endproperty
	a_gain: assert property (p_gain) else $error("gain select wrong");

	property p_span;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) && !$past(bus.ctrl[0][BIT_EXTREF]) |->
			refSrc[0] == ($past(bus.ctrl[0][BIT_SPAN]) ? 2'(SRC_HALF_SUPPLY) : 2'(SRC_BANDGAP));
	endproperty
	a_span: assert property (p_span) else $error("span select wrong");

	property p_extref;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) && $past(bus.ctrl[0][BIT_EXTREF]) |-> refSrc[0] == 2'(SRC_EXTERNAL);
	endproperty
	a_extref: assert property (p_extref) else $error("external reference ignored");

	property p_single;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) |->
			dacPinDriveEnable == ($past(oeBits) != '0) &&
			(!dacPinDriveEnable || (($past(oeBits) >> dacPinChan) & CH'(1)) != '0);
	endproperty
	a_single: assert property (p_single) else $error("DAC pin owner invalid");

	property p_priority;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) && $past(bus.ctrl[0][BIT_DAC_PIN_DRIVE_ENABLE]) |-> dacPinDriveEnable && dacPinChan == 2'h0;
	endproperty
	a_priority: assert property (p_priority) else $error("DAC pin priority wrong");

	property p_code;
		@(posedge clock) disable iff (!rst_n)
		clkEn && rdStb && addr == OFF_THRESHOLD ##1 clkEn |-> rdata[15:10] == 6'h00;
	endproperty
	a_code: assert property (p_code) else $error("threshold upper bits set");

	property p_second_owner;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) && $past(bus.ctrl[1][BIT_DAC_PIN_DRIVE_ENABLE]) && !$past(bus.ctrl[0][BIT_DAC_PIN_DRIVE_ENABLE]) |->
			dacPinDriveEnable && dacPinChan == 2'h1;
	endproperty
	a_second_owner: assert property (p_second_owner) else $error("DAC pin owner not lowest");

	property p_level_path;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) && $past(clkEn, 2) && $past(clkEn, 3) &&
			$past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
			cmpOut[0] == ($past(cmpRaw[0], 3) ^ $past(bus.ctrl[0][BIT_INVERT]));
	endproperty
	a_level_path: assert property (p_level_path) else $error("comparator level path wrong");

	property p_freeze;
		@(posedge clock) disable iff (!rst_n)
		!clkEn |=> $stable(cmpOut) && $stable(hystFalling) && $stable(gainHigh) && $stable(refSrc) &&
			$stable(thresholdCode) && $stable(rdata) && $stable(dacPinChan);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

	property p_read_idle;
		@(posedge clock) disable iff (!rst_n)
		clkEn && !rdStb |=> rdata == '0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not zero when idle");

	property p_code_store;
		@(posedge clock) disable iff (!rst_n)
		clkEn && bus.wrCode && bus.chan == 0 |=> bus.code[0] == $past(wdata[CODE_W-1:0]);
	endproperty
	a_code_store: assert property (p_code_store) else $error("threshold write lost");

	property p_code_out;
		@(posedge clock) disable iff (!rst_n)
		clkEn && $past(clkEn) |-> thresholdCode[0] == $past(bus.code[0]);
	endproperty
	a_code_out: assert property (p_code_out) else $error("threshold output stale");

	property p_code_reset;
		@(posedge clock)
		!rst_n |=> bus.code[0] == '0 && thresholdCode[0] == '0;
	endproperty
	a_code_reset: assert property (p_code_reset) else $error("threshold not reset");

	property p_sel_range;
		@(posedge clock) disable iff (!rst_n)
		clkEn && wrStb && addr == OFF_SELECT && wdata >= 16'(CH) |=> $stable(selFf);
	endproperty
	a_sel_range: assert property (p_sel_range) else $error("out of range select taken");

	property p_ctrl_store;
		@(posedge clock) disable iff (!rst_n)
		clkEn && bus.wrCtrl && bus.chan == 0 |=>
			bus.ctrl[0] == ($past(wdata) & CONTROL_WMASK);
	endproperty
	a_ctrl_store: assert property (p_ctrl_store) else $error("control write lost");

	c_write_ctrl: cover property (@(posedge clock) disable iff (!rst_n) bus.wrCtrl);
	c_read_code: cover property (@(posedge clock) disable iff (!rst_n) rdStb && addr == OFF_THRESHOLD);
	c_pin_drive: cover property (@(posedge clock) disable iff (!rst_n) dacPinDriveEnable);
	c_freeze: cover property (@(posedge clock) disable iff (!rst_n) !clkEn);
	c_ext_ref: cover property (@(posedge clock) disable iff (!rst_n) refSrc[0] == 2'(SRC_EXTERNAL));
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the comparator control register bank
// Assumes: Word addresses, channel select at offset 2, CH of 4
// Notes: Bus driven by NBA just after rising edges
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import cmp_regs_pkg::*;
	localparam int CH = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 16'h0000;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [CH-1:0] cmpRaw = 4'h0;
	logic [CH-1:0] cmpOut;
	logic [CH-1:0] hystFalling;
	logic [CH-1:0] gainHigh;
	logic [CH-1:0][1:0] refSrc;
	logic [CH-1:0][CODE_W-1:0] thresholdCode;
	logic dacPinDriveEnable;
	logic [1:0] dacPinChan;
	int errors = 0;
	int n_checks = 0;
	comparator_control_regs #(.CH(CH)) i_comparator_control_regs (
		.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
		.addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
		.cmpRaw(cmpRaw), .cmpOut(cmpOut), .hystFalling(hystFalling),
		.gainHigh(gainHigh), .refSrc(refSrc), .thresholdCode(thresholdCode),
		.dacPinDriveEnable(dacPinDriveEnable), .dacPinChan(dacPinChan)
	);
	always #2.5 clock = ~clock;
	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		logic [15:0] v;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rd(OFF_CONTROL, v);
		chk(v, 16'h0000);
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h0000);
		wr(OFF_THRESHOLD, 16'hFFFF);
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h03FF);
		settle();
		chk(16'(thresholdCode[0]), 16'h03FF);
		wr(OFF_CONTROL, 16'hFFFF);
		rd(OFF_CONTROL, v);
		chk(v, 16'h013F);
		settle();
		chk(16'(hystFalling[0]), 16'h0001);
		chk(16'(gainHigh[0]), 16'h0001);
		chk(16'(cmpOut[0]), 16'h0001);
		chk(16'(refSrc[0]), 16'(SRC_EXTERNAL));
		wr(OFF_CONTROL, 16'h0001);
		settle();
		chk(16'(refSrc[0]), 16'(SRC_HALF_SUPPLY));
		chk(16'(hystFalling[0]), 16'h0000);
		chk(16'(gainHigh[0]), 16'h0000);
		chk(16'(cmpOut[0]), 16'h0000);
		@(posedge clock);
		cmpRaw <= 4'h1;
		wr(OFF_CONTROL, 16'h0000);
		settle();
		chk(16'(refSrc[0]), 16'(SRC_BANDGAP));
		chk(16'(cmpOut[0]), 16'h0001);
		rd(OFF_CONTROL, v);
		chk(v, 16'h0008);
		wr(OFF_CONTROL, 16'h0002);
		rd(OFF_CONTROL, v);
		chk(v, 16'h0002);
		// Pin ownership across channels, highest first
		for (int c = CH - 1; c >= 1; c--) begin
			wr(OFF_SELECT, 16'(c));
			wr(OFF_CONTROL, 16'h0100);
			settle();
			chk(16'(dacPinDriveEnable), 16'h0001);
			chk(16'(dacPinChan), 16'(c));
		end
		wr(OFF_SELECT, 16'h0000);
		wr(OFF_CONTROL, 16'h0100);
		settle();
		chk(16'(dacPinChan), 16'h0000);
		wr(OFF_CONTROL, 16'h0000);
		wr(OFF_SELECT, 16'h0001);
		wr(OFF_CONTROL, 16'h0000);
		settle();
		chk(16'(dacPinChan), 16'h0002);
		// Select beyond CH ignored, unmapped reads zero
		wr(OFF_SELECT, 16'h0004);
		rd(OFF_SELECT, v);
		chk(v, 16'h0001);
		rd(4'hF, v);
		chk(v, 16'h0000);
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h0000);
		// Write ignored while clock enable low
		@(posedge clock);
		clkEn <= 1'b0;
		wr(OFF_THRESHOLD, 16'h0155);
		clkEn <= 1'b1;
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h0000);
		wr(OFF_THRESHOLD, 16'h02AA);
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h02AA);
		// Reset in mid-run clears stored state
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk(16'(dacPinDriveEnable), 16'h0000);
		chk(16'(thresholdCode[1]), 16'h0000);
		rd(OFF_SELECT, v);
		chk(v, 16'h0000);
		rd(OFF_THRESHOLD, v);
		chk(v, 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
